// ---- include/cpust_map.vh ----
// Register offsets, field positions, reset values and timing counts of the clock throttle block.
`ifndef CPUST_MAP_VH
`define CPUST_MAP_VH

// ==================================================================
// Register offsets
`define CPUST_OFF_PM_CONTROL     8'h04
`define CPUST_OFF_GP_ENABLE      8'h0E
`define CPUST_OFF_PROC_CONTROL   8'h10
`define CPUST_OFF_LEVEL_TWO      8'h14
`define CPUST_OFF_LEVEL_THREE    8'h15

// ==================================================================
// Field positions
`define CPUST_BIT_IRQ_ROUTING    0
`define CPUST_BIT_USB_WAKE       8
`define CPUST_BIT_RING_WAKE      10
`define CPUST_DUTY_MSB           3
`define CPUST_DUTY_LSB           1
`define CPUST_BIT_THROTTLE_EN    4
`define CPUST_BIT_CLOCK_CTRL_EN  5
`define CPUST_BIT_SLEEP_TOGGLE   6
`define CPUST_BIT_BURST_EN       7

// ==================================================================
// Reset values
`define CPUST_RST_PROC_CONTROL   8'h00
`define CPUST_RST_PM_CONTROL     1'b0
`define CPUST_RST_GP_ENABLE      2'h0

// ==================================================================
// Timing counts
`define CPUST_SLOW_TICKS_PER_PERIOD 8
`define CPUST_BURST_TIME_US         32
`define CPUST_CLK_MHZ               100
`define CPUST_BURST_CYCLES          (`CPUST_BURST_TIME_US * `CPUST_CLK_MHZ)

`endif

// ---- src/cpust_duty_gen.v ----
// Throttle period counter on 32 kHz ticks and duty decode for the stop-clock output.
`timescale 1ns/1ps
`include "cpust_map.vh"

module cpust_duty_gen #(
    parameter PERIOD_TICKS = `CPUST_SLOW_TICKS_PER_PERIOD
) (
    input  wire       core_clk,
    input  wire       resetn,
    input  wire       slow_tick,
    input  wire       run,
    input  wire [2:0] duty_code,
    output wire       stop_phase
);

    reg  [2:0] eighth_q;
    wire [3:0] stop_eighths;

    // ==================================================================
    // Duty decode
    // Code 1 gives seven eighths asserted, code 7 one eighth; code 0 is reserved
    // and keeps the processor running rather than halting it outright.
    function [3:0] eighths_of;
        input [2:0] code;
        begin
            if (code == 3'h0) begin
                eighths_of = 4'h0;
            end else begin
                eighths_of = 4'h8 - {1'b0, code};
            end
        end
    endfunction

    assign stop_eighths = eighths_of(duty_code);
    assign stop_phase   = run && ({1'b0, eighth_q} < stop_eighths);

    // ==================================================================
    // Period counter
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            eighth_q <= 3'h0;
        end else if (!run) begin
            eighth_q <= 3'h0;
        end else if (slow_tick) begin
            if ({29'h0, eighth_q} == PERIOD_TICKS - 1) begin
                eighth_q <= 3'h0;
            end else begin
                eighth_q <= eighth_q + 3'h1;
            end
        end
    end

endmodule

// ---- src/cpust_top.v ----
// Processor stop-clock throttle, stop-grant control and control interrupt gating.
`timescale 1ns/1ps
`include "cpust_map.vh"

// Function
// - Bits 3:1 of the processor control register set how much of each throttle period the stop-clock is asserted.
// - Duty code 000 is reserved and codes 001 to 111 give 87.5% down to 12.5% in steps of 12.5%.
// - While throttling the stop-clock toggles every eight 32 kHz periods, and cache sleep follows only when its enable is set.
// - Throttling starts as soon as clock control and throttle enables are both set, with no level-two read.
// - Throttling stops when software clears either the clock control or the throttle enable.
// - Break events do not end throttling; the stop-clock keeps toggling.
// - A level-two read with both enables set enters stop-grant without throttling.
// - A break event in that non-throttled state moves the block into throttled stop-grant.
// - Clearing the clock control enable leaves every clock-control state and restores full speed.
// - Enabled wake events are stop break events when burst enable is clear and burst events when it is set.
// - A stop break returns fully to no clock control; software must read level two or three again to re-enter.
// - Stop break events do not halt throttled stop-grant.
// - Ring status raises the control interrupt only when routing enable and ring enable are both set.
// - USB status raises the control interrupt only when routing enable and USB enable are both set.
module cpust_top #(
    parameter BURST_CYCLES = `CPUST_BURST_CYCLES
) (
    input  wire        core_clk,
    input  wire        resetn,
    input  wire        slow_clk_pin,
    input  wire        wake_event_pin,
    input  wire        io_rd,
    input  wire        io_wr,
    input  wire [7:0]  io_addr,
    input  wire [15:0] io_wdata,
    output reg  [15:0] io_rdata,
    input  wire        ring_event_status,
    input  wire        usb_event_status,
    output reg         cpu_stop_clock_n,
    output reg         cache_sleep_out,
    output reg         system_control_interrupt
);

    localparam ST_FULL     = 2'h0;
    localparam ST_HALT     = 2'h1;
    localparam ST_THROTTLE = 2'h2;
    localparam ST_BURST    = 2'h3;

    reg  [7:0]  processor_control;
    reg         irq_routing_q;
    reg  [1:0]  gp_enable_q;
    reg  [2:0]  slow_sync_q;
    reg         slow_level_q;
    reg  [2:0]  wake_sync_q;
    reg         wake_level_q;
    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg  [31:0] burst_cnt_q;
    wire        slow_tick;
    wire        wake_rise;
    wire        stop_phase;
    wire        clock_control_enable;
    wire        throttle_enable;
    wire        cache_sleep_toggle_enable;
    wire        burst_event_enable;
    wire [2:0]  throttle_duty_code;
    wire        level_two_entry_read;
    wire        level_three_entry_read;
    wire        ring_wake_enable;
    wire        usb_wake_enable;

    assign clock_control_enable      = processor_control[`CPUST_BIT_CLOCK_CTRL_EN];
    assign throttle_enable           = processor_control[`CPUST_BIT_THROTTLE_EN];
    assign cache_sleep_toggle_enable = processor_control[`CPUST_BIT_SLEEP_TOGGLE];
    assign burst_event_enable        = processor_control[`CPUST_BIT_BURST_EN];
    assign throttle_duty_code        = processor_control[`CPUST_DUTY_MSB:`CPUST_DUTY_LSB];
    assign level_two_entry_read      = io_rd && (io_addr == `CPUST_OFF_LEVEL_TWO);
    assign level_three_entry_read    = io_rd && (io_addr == `CPUST_OFF_LEVEL_THREE);
    assign ring_wake_enable          = gp_enable_q[1];
    assign usb_wake_enable           = gp_enable_q[0];

    // ==================================================================
    // Pin synchronisers
    // A level is accepted only when the second and third stages agree, so a
    // slow edge near the sampling point is counted once.
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            slow_sync_q  <= 3'h0;
            slow_level_q <= 1'b0;
            wake_sync_q  <= 3'h0;
            wake_level_q <= 1'b0;
        end else begin
            slow_sync_q <= {slow_sync_q[1:0], slow_clk_pin};
            wake_sync_q <= {wake_sync_q[1:0], wake_event_pin};
            if (slow_sync_q[1] == slow_sync_q[2]) begin
                slow_level_q <= slow_sync_q[2];
            end
            if (wake_sync_q[1] == wake_sync_q[2]) begin
                wake_level_q <= wake_sync_q[2];
            end
        end
    end

    assign slow_tick = (slow_sync_q[1] == slow_sync_q[2]) && slow_sync_q[2] && !slow_level_q;
    assign wake_rise = (wake_sync_q[1] == wake_sync_q[2]) && wake_sync_q[2] && !wake_level_q;

    // ==================================================================
    // Register file
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            processor_control <= `CPUST_RST_PROC_CONTROL;
            irq_routing_q     <= `CPUST_RST_PM_CONTROL;
            gp_enable_q       <= `CPUST_RST_GP_ENABLE;
            io_rdata          <= 16'h0000;
        end else begin
            if (io_wr) begin
                case (io_addr)
                    `CPUST_OFF_PROC_CONTROL: begin
                        processor_control <= {io_wdata[7:1], 1'b0};
                    end
                    `CPUST_OFF_PM_CONTROL: begin
                        irq_routing_q <= io_wdata[`CPUST_BIT_IRQ_ROUTING];
                    end
                    `CPUST_OFF_GP_ENABLE: begin
                        gp_enable_q <= {io_wdata[`CPUST_BIT_RING_WAKE],
                                        io_wdata[`CPUST_BIT_USB_WAKE]};
                    end
                    default: begin
                    end
                endcase
            end
            if (io_rd) begin
                case (io_addr)
                    `CPUST_OFF_PROC_CONTROL: io_rdata <= {8'h00, processor_control};
                    `CPUST_OFF_PM_CONTROL:   io_rdata <= {15'h0000, irq_routing_q};
                    `CPUST_OFF_GP_ENABLE: begin
                        io_rdata <= {5'h00, ring_wake_enable, 1'b0, usb_wake_enable, 8'h00};
                    end
                    `CPUST_OFF_LEVEL_TWO:    io_rdata <= {14'h0000, state_q};
                    default:                 io_rdata <= 16'h0000;
                endcase
            end
        end
    end

    // ==================================================================
    // Clock control state machine
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_FULL: begin
                if (clock_control_enable && (level_two_entry_read || level_three_entry_read)) begin
                    state_d = ST_HALT;
                end else if (clock_control_enable && throttle_enable) begin
                    state_d = ST_THROTTLE;
                end
            end
            ST_HALT: begin
                if (wake_rise) begin
                    if (clock_control_enable && throttle_enable) begin
                        state_d = ST_THROTTLE;
                    end else if (burst_event_enable) begin
                        state_d = ST_BURST;
                    end else begin
                        state_d = ST_FULL;
                    end
                end
            end
            ST_THROTTLE: begin
                if (!throttle_enable) begin
                    state_d = ST_FULL;
                end else if (level_two_entry_read) begin
                    state_d = ST_HALT;
                end
                // A wake event is deliberately ignored here.
            end
            ST_BURST: begin
                if (burst_cnt_q == 32'h0) begin
                    state_d = ST_HALT;
                end
            end
            default: begin
                state_d = ST_FULL;
            end
        endcase
        if (!clock_control_enable) begin
            state_d = ST_FULL;
        end
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q     <= ST_FULL;
            burst_cnt_q <= 32'h0;
        end else begin
            state_q <= state_d;
            if (state_q != ST_BURST && state_d == ST_BURST) begin
                burst_cnt_q <= BURST_CYCLES - 1;
            end else if (burst_cnt_q != 32'h0) begin
                burst_cnt_q <= burst_cnt_q - 32'h1;
            end
        end
    end

    cpust_duty_gen u_duty (
        .core_clk   (core_clk),
        .resetn     (resetn),
        .slow_tick  (slow_tick),
        .run        (state_q == ST_THROTTLE),
        .duty_code  (throttle_duty_code),
        .stop_phase (stop_phase)
    );

    // ==================================================================
    // Outputs
    // Ring and USB status are gated separately so one source cannot leak
    // through the other's enable.
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cpu_stop_clock_n         <= 1'b1;
            cache_sleep_out          <= 1'b0;
            system_control_interrupt <= 1'b0;
        end else begin
            cpu_stop_clock_n <= !((state_q == ST_HALT) || stop_phase);
            cache_sleep_out  <= cache_sleep_toggle_enable &&
                                ((state_q == ST_HALT) || stop_phase);
            system_control_interrupt <= irq_routing_q &&
                ((ring_wake_enable && ring_event_status) ||
                 (usb_wake_enable && usb_event_status));
        end
    end

endmodule

// ---- test/cpust_top_props.sv ----
// Concurrent checks on the ports of the clock throttle block.
`timescale 1ns/1ps
module cpust_top_props (
    input wire        core_clk,
    input wire        resetn,
    input wire        io_rd,
    input wire        io_wr,
    input wire [7:0]  io_addr,
    input wire [15:0] io_wdata,
    input wire [15:0] io_rdata,
    input wire        ring_event_status,
    input wire        usb_event_status,
    input wire        cpu_stop_clock_n,
    input wire        cache_sleep_out,
    input wire        system_control_interrupt
);
    reg  [7:0] pc_q;
    reg  [7:0] rb_q;
    reg  [2:0] en_q;
    wire       irq_w;
    assign irq_w = en_q[0] & ((en_q[2] & ring_event_status) | (en_q[1] & usb_event_status));
    // Shadow copies of the enables, so the interrupt can be tied to its exact cause.
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pc_q <= 8'h00;
            rb_q <= 8'h00;
            en_q <= 3'h0;
        end else begin
            if (io_wr && io_addr == 8'h10)
                pc_q <= io_wdata[7:0];
            if (io_wr && io_addr == 8'h04)
                en_q[0] <= io_wdata[0];
            if (io_wr && io_addr == 8'h0E)
                en_q[2:1] <= {io_wdata[10], io_wdata[8]};
            if (io_rd && io_addr == 8'h10)
                rb_q <= {pc_q[7:1], 1'b0};
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence halt_entry_s;
        io_rd && io_addr == 8'h14 && pc_q[5];
    endsequence
    sequence cc_off_s;
        !pc_q[5] [*3];
    endsequence
    chk_reset_idle: assert property (disable iff (1'b0) !resetn |-> cpu_stop_clock_n &&
        !cache_sleep_out && !system_control_interrupt) else $error("outputs not idle in reset");
    chk_irq_exact: assert property (system_control_interrupt == $past(irq_w))
        else $error("control interrupt does not follow enables and status");
    chk_irq_route: assert property (system_control_interrupt |-> $past(en_q[0]))
        else $error("control interrupt without routing enable");
    chk_halt_stop: assert property (halt_entry_s ##1 !io_wr [*3] |-> !cpu_stop_clock_n)
        else $error("stop-clock not asserted after entry read");
    chk_full_speed: assert property (cc_off_s |=> cpu_stop_clock_n)
        else $error("stop-clock asserted with clock control off");
    chk_sleep_gate: assert property (!pc_q[6] [*3] |=> !cache_sleep_out)
        else $error("cache sleep asserted while its enable is clear");
    chk_rdata_hold: assert property (!io_rd && !$past(io_rd) |=> $stable(io_rdata))
        else $error("read data changed without a read");
    chk_ctrl_readback: assert property (io_rd && io_addr == 8'h10 ##1 !io_rd |=>
        io_rdata[7:0] == rb_q) else $error("control register read back wrong");
endmodule
bind cpust_top cpust_top_props cpust_top_props_i (.core_clk(core_clk), .resetn(resetn),
    .io_rd(io_rd), .io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .ring_event_status(ring_event_status), .usb_event_status(usb_event_status),
    .cpu_stop_clock_n(cpu_stop_clock_n), .cache_sleep_out(cache_sleep_out),
    .system_control_interrupt(system_control_interrupt));

// ---- test/cpust_cpu_model.sv ----
// Processor side model: runs while stop-clock is high and counts stop-grant entries.
`timescale 1ns/1ps
module cpust_cpu_model (
    input  wire        core_clk,
    input  wire        cpu_stop_clock_n,
    output reg         cpu_running,
    output reg  [15:0] stop_grants
);
    initial cpu_running = 1'b1;
    initial stop_grants = 16'h0000;
    always @(posedge core_clk) begin
        cpu_running <= cpu_stop_clock_n;
        if (!cpu_stop_clock_n && cpu_running)
            stop_grants <= stop_grants + 16'h0001;
    end
endmodule

// ---- test/test_cpust_top.sv ----
// Self-checking bench for the clock throttle block.
`timescale 1ns/1ps
module test_cpust_top;
    reg         core_clk = 1'b0, resetn = 1'b1, slow_clk_pin = 1'b0, wake_event_pin = 1'b0;
    reg         io_rd = 1'b0, io_wr = 1'b0, ring_event_status = 1'b0, usb_event_status = 1'b0;
    reg  [7:0]  io_addr = 8'h00;
    reg  [15:0] io_wdata = 16'h0000, lo, sl, g, rd, e;
    wire [15:0] io_rdata, stop_grants;
    wire        cpu_stop_clock_n, cache_sleep_out, system_control_interrupt, cpu_running;
    integer     errors = 0, n_compared = 0, cycles = 0, i;
    cpust_top #(.BURST_CYCLES(4)) cpust_top_i (.core_clk(core_clk), .resetn(resetn),
        .slow_clk_pin(slow_clk_pin), .wake_event_pin(wake_event_pin), .io_rd(io_rd),
        .io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .ring_event_status(ring_event_status), .usb_event_status(usb_event_status),
        .cpu_stop_clock_n(cpu_stop_clock_n), .cache_sleep_out(cache_sleep_out),
        .system_control_interrupt(system_control_interrupt));
    cpust_cpu_model cpust_cpu_model_i (.core_clk(core_clk), .cpu_stop_clock_n(cpu_stop_clock_n),
        .cpu_running(cpu_running), .stop_grants(stop_grants));
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    // The slow clock is 20 core cycles so a throttle period fits the run; odd phase on purpose.
    initial begin
        #3;
        forever #100 slow_clk_pin = ~slow_clk_pin;
    end
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 8000) begin
            errors = errors + 1;
            finish_test;
        end
    end
    task finish_test;
        begin
            $display("compared %0d errors %0d", n_compared, errors);
            if (errors == 0 && n_compared > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input [15:0] exp, input [15:0] got, input [63:0] name);
        begin
            n_compared = n_compared + 1;
            if (exp !== got) begin
                errors = errors + 1;
                $display("MISMATCH %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task wr(input [7:0] a, input [15:0] d);
        begin
            @(negedge core_clk);
            {io_addr, io_wdata, io_wr} = {a, d, 1'b1};
            @(negedge core_clk);
            io_wr = 1'b0;
        end
    endtask
    task rdr(input [7:0] a);
        begin
            @(negedge core_clk);
            {io_addr, io_rd} = {a, 1'b1};
            @(negedge core_clk);
            io_rd = 1'b0;
            @(negedge core_clk);
            rd = io_rdata;
        end
    endtask
    // Eight consecutive mid-tick samples cover one throttle period whatever its phase.
    task measure;
        begin
            lo = 16'h0000;
            sl = 16'h0000;
            repeat (2) @(posedge slow_clk_pin);
            repeat (8) begin
                @(negedge slow_clk_pin);
                lo = lo + {15'h0000, ~cpu_running};
                sl = sl + {15'h0000, cache_sleep_out};
            end
        end
    endtask
    task wake;
        begin
            @(negedge core_clk);
            wake_event_pin = 1'b1;
            repeat (4) @(negedge core_clk);
            wake_event_pin = 1'b0;
        end
    endtask
    // Reset falls after time zero so the asynchronous reset really fires before the first edge.
    initial begin
        #1 resetn = 1'b0;
        repeat (5) @(negedge core_clk);
        resetn = 1'b1;
        rdr(8'h10);
        chk(16'h0000, rd, "pc_rst");
        wr(8'h10, 16'h00FE);
        rdr(8'h10);
        chk(16'h00FE, rd, "pc_rw");
        rdr(8'h33);
        chk(16'h0000, rd, "unmapped");
        for (i = 0; i < 8; i = i + 1) begin
            wr(8'h10, {8'h00, 1'b0, i[0], 2'b11, i[2:0], 1'b0});
            measure;
            e = (i == 0) ? 16'h0000 : 16'h0008 - i[15:0];
            chk(e, lo, "duty_lo");
            chk(i[0] ? e : 16'h0000, sl, "duty_sl");
        end
        wr(8'h10, 16'h0034);
        wake;
        measure;
        chk(16'h0006, lo, "stop_lo");
        wr(8'h10, 16'h0024);
        measure;
        chk(16'h0000, lo, "stop_lo");
        wr(8'h10, 16'h0034);
        rdr(8'h14);
        measure;
        chk(16'h0008, lo, "stop_lo");
        wake;
        measure;
        chk(16'h0006, lo, "stop_lo");
        wr(8'h10, 16'h0014);
        measure;
        chk(16'h0000, lo, "stop_lo");
        wr(8'h10, 16'h0020);
        rdr(8'h15);
        measure;
        chk(16'h0008, lo, "stop_lo");
        wake;
        measure;
        chk(16'h0000, lo, "stop_lo");
        wr(8'h10, 16'h00A0);
        rdr(8'h14);
        measure;
        g = stop_grants;
        wake;
        repeat (100) @(negedge core_clk);
        chk(g + 16'h0001, stop_grants, "burst");
        for (i = 0; i < 32; i = i + 1) begin
            wr(8'h04, {15'h0000, i[0]});
            wr(8'h0E, {5'h00, i[1], 1'b0, i[2], 8'h00});
            {ring_event_status, usb_event_status} = {i[3], i[4]};
            repeat (3) @(negedge core_clk);
            chk({15'h0000, i[0] & ((i[1] & i[3]) | (i[2] & i[4]))},
                {15'h0000, system_control_interrupt}, "irq");
            rdr(8'h0E);
            chk({5'h00, i[1], 1'b0, i[2], 8'h00}, rd, "gpen");
            rdr(8'h04);
            chk({15'h0000, i[0]}, rd, "pmctl");
        end
        finish_test;
    end
endmodule
